// ==== src/acsc_map.svh ====
// register offsets, field positions, write masks and reset values
// of the converter sequencer; included by the sequencer and the bench, not by the package.
`ifndef ACSC_MAP_SVH
`define ACSC_MAP_SVH
// ==========================================
// word offsets on the register port
`define ACSC_OFF_CON2 4'h0
`define ACSC_OFF_CON3 4'h1
`define ACSC_OFF_CHS123 4'h2
`define ACSC_OFF_CHS0 4'h3
`define ACSC_OFF_CTRL 4'h4
`define ACSC_OFF_SCAN 4'h5
`define ACSC_OFF_STAT 4'h6
// ==========================================
// writable bits of each register
`define ACSC_MASK_CON2 16'he73f
`define ACSC_MASK_CON3 16'h9fff
`define ACSC_MASK_CHS123 16'h0707
`define ACSC_MASK_CHS0 16'h9f9f
`define ACSC_MASK_CTRL 16'h84e0
`define ACSC_MASK_SCAN 16'h003f
`define ACSC_RESET 16'h0000
// ==========================================
// field positions
`define ACSC_BUFFER_FILL_STATUS_BIT 7
`define ACSC_CHANNEL_COUNT_LO 8
`define ACSC_ENABLE_BIT 15
`define ACSC_RES_BIT 10
`define ACSC_TRIG_LO 5
`define ACSC_TRIG_AUTO 3'h7
`define ACSC_NUM_INPUTS 6
`endif

// ==== src/acsc_pkg.sv ====
// types shared by the converter sequencer design.
// assumes nothing beyond a SystemVerilog compiler.
package acsc_pkg;
  // ==========================================
  // sequencer states
  typedef enum logic [1:0] {
    ACSC_IDLE = 2'b00,
    ACSC_SAMPLE = 2'b01,
    ACSC_CONVERT = 2'b10
  } acsc_state_t;
endpackage

// ==== src/acsc_seq.sv ====
// converter sequencer control: registers, clock divider, sample timing,
// input selection, interrupt pacing and buffer half tracking.
// assumes the converter front end pulses seq_done once per sequence.
//
// How it works
// - reference select picks supply, ground or external references; 1xx means supply/ground.
// - scan enable steps channel 0 positive input through scanned inputs during sample A.
// - channel count code 1x gives four channels, 01 two, 00 one.
// - in twelve-bit mode channel count reads zero and only channel 0 converts.
// - buffer fill status reads which half the converter is filling.
// - interrupt fires after every pacing-plus-one completed sequences.
// - split mode alternates buffer halves per interrupt, otherwise always first half.
// - alternate sampling swaps sample A and sample B selects on each sequence.
// - clock source bit picks the internal RC clock or the divided system clock.
// - auto-sample time counts 0 to 31 conversion clock periods.
// - divided conversion clock period is divider value plus one system cycles.
// - channels 1-3 negative codes 00 and 01 use negative reference in ten-bit mode.
// - channels 1-3 positive select 0 connects inputs 0, 1 and 2.
// - positive select 1 connects inputs 3, 4, 5; small variant leaves 2 and 3 open.
// - channel 0 negative select 1 takes input 1, else negative reference.
// - channel 0 positive code names the input, up to the variant's last input.
// - unimplemented bits ignore writes and read zero.
// - resolution bit picks twelve-bit single channel or ten-bit four channel.
// - trigger code 111 ends sampling after the auto-sample time and starts conversion.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "acsc_map.svh"

module acsc_seq #(
  parameter int SIX_INPUTS = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // converter front end
  input wire logic rc_clk_in,
  input wire logic ext_trigger,
  input wire logic seq_done,
  output logic conv_start,
  output logic sampling,
  output logic tad_tick,
  // selections toward the analog side
  output logic ref_pos_ext,
  output logic ref_neg_ext,
  output logic [1:0] active_channels,
  output logic [4:0] ch0_pos_input,
  output logic ch0_pos_valid,
  output logic ch0_neg_an1,
  output logic ch123_pos_high,
  output logic [2:0] ch123_valid,
  output logic sample_b,
  // result buffer and interrupt
  output logic buf_half,
  output logic seq_irq
);
  import acsc_pkg::*;

  // ==========================================
  // helpers
  function automatic logic [2:0] next_scan(input logic [2:0] cur, input logic [5:0] mask);
    logic [2:0] res;
    logic [2:0] idx;
    logic found;
    res = cur;
    found = 1'b0;
    idx = cur;
    for (int i = 0; i < `ACSC_NUM_INPUTS; i++) begin
      idx = (idx == 3'h5) ? 3'h0 : idx + 3'h1;
      if (!found && mask[idx]) begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  function automatic logic [15:0] masked_write(input logic [15:0] wd, input logic [15:0] mask);
    return wd & mask;
  endfunction

  // ==========================================
  // registers
  logic [15:0] con2_r, con3_r, chs123_r, chs0_r, ctrl_r, scan_r;
  logic reg_hit_con2, reg_hit_con3, reg_hit_chs123, reg_hit_chs0, reg_hit_ctrl, reg_hit_scan;

  assign reg_hit_con2 = reg_wr && reg_addr == `ACSC_OFF_CON2;
  assign reg_hit_con3 = reg_wr && reg_addr == `ACSC_OFF_CON3;
  assign reg_hit_chs123 = reg_wr && reg_addr == `ACSC_OFF_CHS123;
  assign reg_hit_chs0 = reg_wr && reg_addr == `ACSC_OFF_CHS0;
  assign reg_hit_ctrl = reg_wr && reg_addr == `ACSC_OFF_CTRL;
  assign reg_hit_scan = reg_wr && reg_addr == `ACSC_OFF_SCAN;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      con2_r <= `ACSC_RESET;
      con3_r <= `ACSC_RESET;
      chs123_r <= `ACSC_RESET;
      chs0_r <= `ACSC_RESET;
      ctrl_r <= `ACSC_RESET;
      scan_r <= `ACSC_RESET;
    end else begin
      // status bit and unimplemented bits are never stored
      if (reg_hit_con2) con2_r <= masked_write(reg_wdata, `ACSC_MASK_CON2);
      if (reg_hit_con3) con3_r <= masked_write(reg_wdata, `ACSC_MASK_CON3);
      if (reg_hit_chs123) chs123_r <= masked_write(reg_wdata, `ACSC_MASK_CHS123);
      if (reg_hit_chs0) chs0_r <= masked_write(reg_wdata, `ACSC_MASK_CHS0);
      if (reg_hit_ctrl) ctrl_r <= masked_write(reg_wdata, `ACSC_MASK_CTRL);
      if (reg_hit_scan) scan_r <= masked_write(reg_wdata, `ACSC_MASK_SCAN);
    end
  end

  // field views
  logic [2:0] reference_select;
  logic scan_enable;
  logic [1:0] channel_count;
  logic [3:0] interrupt_pacing;
  logic buffer_fill_mode, alternate_sampling;
  logic conv_clock_source;
  logic [4:0] auto_sample_time;
  logic [7:0] conv_clock_divider;
  logic module_on, resolution_mode;
  logic [2:0] trigger_source;

  assign reference_select = con2_r[15:13];
  assign scan_enable = con2_r[10];
  assign channel_count = con2_r[9:8];
  assign interrupt_pacing = con2_r[5:2];
  assign buffer_fill_mode = con2_r[1];
  assign alternate_sampling = con2_r[0];
  assign conv_clock_source = con3_r[15];
  assign auto_sample_time = con3_r[12:8];
  assign conv_clock_divider = con3_r[7:0];
  assign module_on = ctrl_r[`ACSC_ENABLE_BIT];
  assign resolution_mode = ctrl_r[`ACSC_RES_BIT];
  assign trigger_source = ctrl_r[`ACSC_TRIG_LO+:3];

  // ==========================================
  // turn-on detection
  logic on_d_r;
  logic on_rise;

  always_ff @(posedge core_clk) begin
    if (srst) on_d_r <= 1'b0;
    else on_d_r <= module_on;
  end
  assign on_rise = module_on && !on_d_r;

  // ==========================================
  // conversion clock
  logic rc_s1_r, rc_s2_r, rc_s3_r;
  logic [7:0] div_cnt_r;
  logic div_hit, rc_rise;

  // the RC clock is asynchronous; only the 2nd and 3rd stage are compared
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
    end else begin
      rc_s1_r <= rc_clk_in;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
    end
  end
  assign rc_rise = rc_s2_r && !rc_s3_r;

  // >= so a divider lowered mid-count cannot run the counter round 256
  assign div_hit = div_cnt_r >= conv_clock_divider;

  always_ff @(posedge core_clk) begin
    if (srst) div_cnt_r <= 8'h00;
    else if (div_hit || conv_clock_source) div_cnt_r <= 8'h00;
    else div_cnt_r <= div_cnt_r + 8'h01;
  end

  assign tad_tick = conv_clock_source ? rc_rise : div_hit;

  // ==========================================
  // sample and convert sequencing
  acsc_state_t state_r;
  logic [4:0] samp_cnt_r;
  logic conv_start_r;
  logic samp_end, auto_trig;

  assign auto_trig = trigger_source == `ACSC_TRIG_AUTO;
  assign samp_end = auto_trig ? (samp_cnt_r == auto_sample_time) : ext_trigger;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= ACSC_IDLE;
      samp_cnt_r <= 5'h00;
      conv_start_r <= 1'b0;
    end else begin
      conv_start_r <= 1'b0;
      case (state_r)
        ACSC_IDLE: begin
          samp_cnt_r <= 5'h00;
          if (module_on) state_r <= ACSC_SAMPLE;
        end
        ACSC_SAMPLE: begin
          if (!module_on) begin
            state_r <= ACSC_IDLE;
          end else if (samp_end) begin
            conv_start_r <= 1'b1;
            samp_cnt_r <= 5'h00;
            state_r <= ACSC_CONVERT;
          end else if (tad_tick) begin
            samp_cnt_r <= samp_cnt_r + 5'h01;
          end
        end
        ACSC_CONVERT: begin
          if (!module_on) state_r <= ACSC_IDLE;
          else if (seq_done) state_r <= ACSC_SAMPLE;
        end
        default: state_r <= ACSC_IDLE;
      endcase
    end
  end

  assign conv_start = conv_start_r;
  assign sampling = state_r == ACSC_SAMPLE;

  // ==========================================
  // pacing, buffer halves, A/B toggle, scan pointer
  logic [3:0] seq_cnt_r;
  logic buf_half_r, sample_b_r, seq_irq_r;
  logic [2:0] scan_ptr_r;
  logic at_terminal, use_b;

  assign at_terminal = seq_cnt_r == interrupt_pacing;
  assign use_b = alternate_sampling && sample_b_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      seq_cnt_r <= 4'h0;
      buf_half_r <= 1'b0;
      seq_irq_r <= 1'b0;
    end else begin
      seq_irq_r <= 1'b0;
      if (on_rise) begin
        seq_cnt_r <= 4'h0;
        buf_half_r <= 1'b0;
      end else if (seq_done) begin
        if (at_terminal) begin
          seq_cnt_r <= 4'h0;
          seq_irq_r <= 1'b1;
          buf_half_r <= buffer_fill_mode ? !buf_half_r : 1'b0;
        end else begin
          seq_cnt_r <= seq_cnt_r + 4'h1;
        end
      end else if (!buffer_fill_mode) begin
        buf_half_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) sample_b_r <= 1'b0;
    else if (on_rise) sample_b_r <= 1'b0;
    else if (seq_done && alternate_sampling) sample_b_r <= !sample_b_r;
    else if (!alternate_sampling) sample_b_r <= 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (srst) scan_ptr_r <= 3'h0;
    else if (on_rise) scan_ptr_r <= 3'h0;
    else if (seq_done && scan_enable && !use_b) scan_ptr_r <= next_scan(scan_ptr_r, scan_r[5:0]);
  end

  assign buf_half = buf_half_r;
  assign seq_irq = seq_irq_r;
  assign sample_b = sample_b_r;

  // ==========================================
  // input and reference selection, registered toward the analog side
  logic [4:0] ch0_code;
  logic [1:0] neg_code;
  logic pos_high;

  assign ch0_code = use_b ? chs0_r[12:8] : (scan_enable ? {2'b00, scan_ptr_r} : chs0_r[4:0]);
  assign neg_code = use_b ? chs123_r[10:9] : chs123_r[2:1];
  assign pos_high = use_b ? chs123_r[8] : chs123_r[0];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ref_pos_ext <= 1'b0;
      ref_neg_ext <= 1'b0;
      active_channels <= 2'b00;
      ch0_pos_input <= 5'h00;
      ch0_pos_valid <= 1'b0;
      ch0_neg_an1 <= 1'b0;
      ch123_pos_high <= 1'b0;
      ch123_valid <= 3'h0;
    end else begin
      ref_pos_ext <= !reference_select[2] && reference_select[0];
      ref_neg_ext <= !reference_select[2] && reference_select[1];
      if (resolution_mode) active_channels <= 2'b00;
      else if (channel_count[1]) active_channels <= 2'b11;
      else active_channels <= channel_count;
      ch0_pos_input <= ch0_code;
      ch0_pos_valid <= ch0_code <= (SIX_INPUTS != 0 ? 5'h05 : 5'h03);
      ch0_neg_an1 <= use_b ? chs0_r[15] : chs0_r[7];
      ch123_pos_high <= pos_high;
      // reserved codes and twelve-bit mode leave channels 1-3 disconnected
      if (resolution_mode || neg_code[1]) begin
        ch123_valid <= 3'h0;
      end else begin
        ch123_valid[0] <= 1'b1;
        ch123_valid[1] <= SIX_INPUTS != 0 || !pos_high;
        ch123_valid[2] <= SIX_INPUTS != 0 || !pos_high;
      end
    end
  end

  // ==========================================
  // register read port, data one cycle after the strobe
  logic [15:0] rd_word;

  always_comb begin
    rd_word = 16'h0000;
    case (reg_addr)
      `ACSC_OFF_CON2: begin
        rd_word = con2_r;
        if (resolution_mode) rd_word[`ACSC_CHANNEL_COUNT_LO+:2] = 2'b00;
        rd_word[`ACSC_BUFFER_FILL_STATUS_BIT] = buf_half_r;
      end
      `ACSC_OFF_CON3: rd_word = con3_r;
      `ACSC_OFF_CHS123: rd_word = chs123_r;
      `ACSC_OFF_CHS0: rd_word = chs0_r;
      `ACSC_OFF_CTRL: rd_word = ctrl_r;
      `ACSC_OFF_SCAN: rd_word = scan_r;
      `ACSC_OFF_STAT: rd_word = {5'h00, scan_ptr_r, 1'b0, sample_b_r, seq_cnt_r, state_r};
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) reg_rdata <= 16'h0000;
    else if (reg_rd) reg_rdata <= rd_word;
    else reg_rdata <= 16'h0000;
  end

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_samp_end;
    state_r == ACSC_SAMPLE && module_on && auto_trig && samp_cnt_r == auto_sample_time;
  endsequence

  sequence s_pace_end;
    seq_done && at_terminal && !on_rise;
  endsequence

  property p_ref_ext;
    reference_select == 3'h3 |=> ref_pos_ext && ref_neg_ext;
  endproperty
  a_ref_ext: assert property (p_ref_ext) else $error("external references not selected");

  property p_ref_int;
    reference_select[2] |=> !ref_pos_ext && !ref_neg_ext;
  endproperty
  a_ref_int: assert property (p_ref_int) else $error("1xx reference code not supply and ground");

  property p_twelve_one_ch;
    resolution_mode |=> active_channels == 2'b00;
  endproperty
  a_twelve_one_ch: assert property (p_twelve_one_ch) else $error("twelve-bit mode with extra channels");

  property p_channel_count_read;
    reg_rd && reg_addr == `ACSC_OFF_CON2 && resolution_mode |=> reg_rdata[9:8] == 2'b00;
  endproperty
  a_channel_count_read: assert property (p_channel_count_read) else $error("channel count not read as zero");

  property p_pace_irq;
    s_pace_end |=> seq_irq && buf_half == ($past(buffer_fill_mode) ? !$past(buf_half) : 1'b0);
  endproperty
  a_pace_irq: assert property (p_pace_irq) else $error("interrupt or buffer half wrong at pacing end");

  property p_no_early_irq;
    seq_done && !at_terminal |=> !seq_irq;
  endproperty
  a_no_early_irq: assert property (p_no_early_irq) else $error("interrupt before pacing count");

  property p_alt_toggle;
    alternate_sampling && seq_done && !on_rise |=> sample_b != $past(sample_b);
  endproperty
  a_alt_toggle: assert property (p_alt_toggle) else $error("sample A/B did not alternate");

  property p_div_zero;
    (!conv_clock_source && conv_clock_divider == 8'h00)[*2] |-> tad_tick;
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("divider zero not one cycle period");

  property p_auto_convert;
    s_samp_end |=> conv_start ##1 !conv_start;
  endproperty
  a_auto_convert: assert property (p_auto_convert) else $error("auto-sample end did not start conversion");

  property p_turn_on;
    on_rise |=> seq_cnt_r == 4'h0 && !sample_b;
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("counters not restarted at turn on");

endmodule

// ==== verification/acsc_conv_model.sv ====
// converter front end model: answers each conversion start with one done pulse.
// assumes conv_start is a one-cycle pulse in the core_clk domain.
`timescale 1ns/1ps
module acsc_conv_model #(
  parameter int LAT = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // sequencer side
  input wire logic conv_start,
  output logic seq_done
);
  // ==========================================
  // conversion delay
  // a start during a conversion restarts it, as a real front end would
  int cnt;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt <= 0;
      seq_done <= 1'b0;
    end else begin
      seq_done <= (cnt == 1);
      if (conv_start) begin
        cnt <= LAT;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ==== verification/acsc_seq_tb_top.sv ====
// self-checking bench of the converter sequencer with a front end model.
// assumes the register map header and the hand-over latencies.
`timescale 1ns/1ps
`include "acsc_map.svh"
module acsc_seq_tb_top;
  // ==========================================
  // stimulus and wiring
  logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic rc_clk_in = 1'b0, rc_run = 1'b0, ext_trigger = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic seq_done, conv_start, sampling, tad_tick, ref_pos_ext, ref_neg_ext;
  logic ch0_pos_valid, ch0_neg_an1, ch123_pos_high, sample_b, buf_half, seq_irq;
  logic [1:0] active_channels;
  logic [4:0] ch0_pos_input;
  logic [2:0] ch123_valid;
  int err_total, num_checks, cyc, t_last, gap, slen, scap, n_done, n_irq, n_tad, irq_bad, b0, b1;
  logic d_prev;
  logic [4:0] pos_q [$];
  int exp_pos [4] = '{0, 2, 5, 0};
  logic [15:0] masks [4] = '{`ACSC_MASK_CON2, `ACSC_MASK_CON3, `ACSC_MASK_CHS123, `ACSC_MASK_CHS0};

  always #2.5 core_clk = ~core_clk;
  // rc clock deliberately off the core grid
  always #20.3 rc_clk_in = rc_run ? ~rc_clk_in : 1'b0;

  acsc_seq acsc_seq_i (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_clk_in(rc_clk_in),
    .ext_trigger(ext_trigger), .seq_done(seq_done), .conv_start(conv_start), .sampling(sampling),
    .tad_tick(tad_tick), .ref_pos_ext(ref_pos_ext), .ref_neg_ext(ref_neg_ext),
    .active_channels(active_channels), .ch0_pos_input(ch0_pos_input), .ch0_pos_valid(ch0_pos_valid),
    .ch0_neg_an1(ch0_neg_an1), .ch123_pos_high(ch123_pos_high), .ch123_valid(ch123_valid),
    .sample_b(sample_b), .buf_half(buf_half), .seq_irq(seq_irq));
  acsc_conv_model acsc_conv_model_i (.core_clk(core_clk), .srst(srst), .conv_start(conv_start),
    .seq_done(seq_done));

  // ==========================================
  // monitors
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    d_prev <= seq_done;
    if (tad_tick === 1'b1) begin
      gap <= cyc - t_last;
      t_last <= cyc;
      n_tad <= n_tad + 1;
    end
    slen <= (sampling === 1'b1) ? slen + 1 : 0;
    if (conv_start === 1'b1) begin
      scap <= slen;
      pos_q.push_back(ch0_pos_input);
    end
    if (seq_done === 1'b1) n_done <= n_done + 1;
    if (seq_irq === 1'b1) begin
      n_irq <= n_irq + 1;
      if (d_prev !== 1'b1) irq_bad <= irq_bad + 1;
    end
  end

  // ==========================================
  // access and compare tasks
  // every strobe and wait task ends 1 ns after an edge so no strobe is driven twice in one step
  task automatic tk(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(int got, int lo, int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("MISMATCH t=%0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic rdchk(logic [3:0] a, logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic wait_done(int n);
    for (int k = 0; k < 3000 && n_done < n; k++) @(posedge core_clk);
    #1;
  endtask
  task automatic end_test(string s);
    $display("test %s done", s);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #100us;
    err_total++;
    wrap_up();
  end

  // ==========================================
  // tests
  initial begin
    tk(16);
    srst <= 1'b0;
    tk(2);
    for (int i = 0; i < 8; i++) rdchk(i[3:0], `ACSC_RESET);
    for (int i = 0; i < 4; i++) begin
      wr(i[3:0], 16'hffff);
      rdchk(i[3:0], masks[i]);
    end
    wr(4'h7, 16'hffff);
    rdchk(4'h7, 16'h0000);
    for (int i = 0; i < 4; i++) wr(i[3:0], 16'h0000);
    end_test("registers");
    for (int c = 0; c < 8; c++) begin
      wr(`ACSC_OFF_CON2, 16'(c << 13));
      tk(2);
      chk(16'({ref_pos_ext, ref_neg_ext}), (c < 4) ? 16'({c[0], c[1]}) : 16'h0000);
    end
    for (int c = 0; c < 4; c++) begin
      wr(`ACSC_OFF_CON2, 16'(c << 8));
      tk(2);
      chk(16'(active_channels), c[1] ? 16'h0003 : 16'(c));
    end
    wr(`ACSC_OFF_CTRL, 16'h0400);
    wr(`ACSC_OFF_CON2, 16'h0300);
    tk(2);
    chk(16'(active_channels), 16'h0000);
    rdchk(`ACSC_OFF_CON2, 16'h0000);
    wr(`ACSC_OFF_CTRL, 16'h0000);
    end_test("references and channels");
    for (int c = 0; c < 8; c++) begin
      wr(`ACSC_OFF_CHS0, {8'h00, c[0], 2'b00, c[4:0]});
      tk(2);
      chk({ch0_neg_an1, ch0_pos_valid, 9'h000, ch0_pos_input}, {c[0], c < 6, 9'h000, c[4:0]});
    end
    for (int c = 0; c < 2; c++) begin
      wr(`ACSC_OFF_CHS123, 16'(c));
      tk(2);
      chk(16'(ch123_pos_high), 16'(c));
      chk(16'(ch123_valid), 16'h0007);
    end
    // reserved negative code leaves channels 1-3 open
    wr(`ACSC_OFF_CHS123, 16'h0004);
    tk(2);
    chk(16'(ch123_valid), 16'h0000);
    wr(`ACSC_OFF_CHS123, 16'h0000);
    wr(`ACSC_OFF_CTRL, 16'h0400);
    tk(2);
    chk(16'(ch123_valid), 16'h0000);
    wr(`ACSC_OFF_CTRL, 16'h0000);
    wr(`ACSC_OFF_CHS0, 16'h0000);
    end_test("input selects");
    // pacing every third sequence, split buffer, alternate sampling
    wr(`ACSC_OFF_CON3, 16'h0301);
    wr(`ACSC_OFF_CON2, 16'h000b);
    wr(`ACSC_OFF_CTRL, 16'h80e0);
    wait_done(3);
    tk(2);
    chk(16'({buf_half, sample_b}), 16'h0003);
    rdchk(`ACSC_OFF_CON2, 16'h008b);
    chk_n(gap, 2, 2);
    chk_n(scap, 5, 8);
    wait_done(7);
    tk(2);
    chk_n(n_irq, 2, 2);
    chk_n(irq_bad, 0, 0);
    chk(16'(buf_half), 16'h0000);
    wr(`ACSC_OFF_CTRL, 16'h0000);
    tk(8);
    wr(`ACSC_OFF_CTRL, 16'h80e0);
    b0 = n_done;
    b1 = n_irq;
    wait_done(b0 + 2);
    tk(2);
    chk_n(n_irq - b1, 0, 0);
    chk(16'(sample_b), 16'h0000);
    wait_done(b0 + 3);
    tk(2);
    chk_n(n_irq - b1, 1, 1);
    end_test("sequencing");
    wr(`ACSC_OFF_CTRL, 16'h0000);
    tk(8);
    wr(`ACSC_OFF_SCAN, 16'h0025);
    wr(`ACSC_OFF_CON2, 16'h0400);
    pos_q.delete();
    wr(`ACSC_OFF_CTRL, 16'h80e0);
    wait_done(n_done + 4);
    for (int k = 0; k < 4; k++) chk(16'(pos_q[k]), 16'(exp_pos[k]));
    end_test("scan");
    wr(`ACSC_OFF_CTRL, 16'h0000);
    wr(`ACSC_OFF_CON3, 16'h1f04);
    wr(`ACSC_OFF_CTRL, 16'h80e0);
    tk(3);
    b0 = n_tad;
    tk(100);
    chk_n(n_tad - b0, 20, 20);
    wr(`ACSC_OFF_CTRL, 16'h0000);
    wr(`ACSC_OFF_CON3, 16'h9f04);
    rc_run = 1'b1;
    wr(`ACSC_OFF_CTRL, 16'h80e0);
    tk(10);
    b0 = n_tad;
    tk(160);
    chk_n(n_tad - b0, 18, 21);
    end_test("clock sources");
    // external trigger: no conversion until the pulse arrives
    wr(`ACSC_OFF_CTRL, 16'h0000);
    tk(8);
    wr(`ACSC_OFF_CTRL, 16'h8000);
    b0 = n_done;
    tk(40);
    chk_n(n_done - b0, 0, 0);
    ext_trigger <= 1'b1;
    @(posedge core_clk);
    ext_trigger <= 1'b0;
    #1;
    wait_done(b0 + 1);
    chk_n(n_done - b0, 1, 1);
    end_test("external trigger");
    wrap_up();
  end
endmodule
